// ---- hw/otgc_defines.svh ----
// constants, register map and timing of the otg controller core
`ifndef OTGC_DEFINES_SVH
`define OTGC_DEFINES_SVH

`define OTGC_CLK_MHZ 25
`define OTGC_SUSP_IDLE_US 3000
`define OTGC_BUS_RST_NS 2500
`define OTGC_EOPF_NS 999000
`define OTGC_RWAKE_US 2000
`define OTGC_SRP_PULSE_US 7000
`define OTGC_HNP_WAIT_US 3000
`define OTGC_TW 24

`define OTGC_FIFO_BYTES 1280
`define OTGC_NREG 5
`define OTGC_RX_DEPTH_RST 9'h080
`define OTGC_TX_DEPTH_RST 9'h030
`define OTGC_SPEED_FULL 2'h3

`define OTGC_A_CS 16'h0000
`define OTGC_A_GIF 16'h0004
`define OTGC_A_DCTL 16'h0008
`define OTGC_A_DSTAT 16'h000c
`define OTGC_A_GCFG 16'h0010
`define OTGC_A_RXLEN 16'h0014
`define OTGC_A_TXLEN0 16'h0018
`define OTGC_A_TXLEN1 16'h001c
`define OTGC_A_TXLEN2 16'h0020
`define OTGC_A_TXLEN3 16'h0024
`define OTGC_A_HPCS 16'h0028
`define OTGC_A_RSTAT_RD 16'h002c
`define OTGC_A_RSTAT_POP 16'h0030
`define OTGC_A_CHTYPE 16'h0034

`define OTGC_CS_SESSION_REQUEST_BIT 3
`define OTGC_CS_NEGOTIATION_REQUEST_BIT 5
`define OTGC_GIF_RST 0
`define OTGC_GIF_ENUM 1
`define OTGC_GIF_SOF 2
`define OTGC_GIF_EOPF 3
`define OTGC_GIF_WKUP 4
`define OTGC_GIF_SUSP 5
`define OTGC_GIF_SESI 6
`define OTGC_F_START 8:0
`define OTGC_F_DEPTH 24:16

`endif

// ---- hw/otgc_pkg.sv ----
// types of the otg controller core
`default_nettype none
package otgc_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_ATT = 3'b001,
      ST_SUSP = 3'b010,
      ST_RWAKE = 3'b011,
      ST_SRP = 3'b100,
      ST_HNP = 3'b101
   } otgc_state_type;
endpackage
`default_nettype wire

// ---- hw/otgc_core.sv ----
// otg controller core: device link state, otg role logic and packet fifo
`timescale 1ns/1ns
`default_nettype none
`include "otgc_defines.svh"
module otgc_core #(
   parameter int SUSP_CYC = `OTGC_SUSP_IDLE_US * `OTGC_CLK_MHZ,
   parameter int EOPF_CYC = (`OTGC_EOPF_NS * `OTGC_CLK_MHZ) / 1000,
   parameter int RWAKE_CYC = `OTGC_RWAKE_US * `OTGC_CLK_MHZ,
   parameter int SRP_CYC = `OTGC_SRP_PULSE_US * `OTGC_CLK_MHZ,
   parameter int HNP_CYC = `OTGC_HNP_WAIT_US * `OTGC_CLK_MHZ,
   parameter int WORDS = `OTGC_FIFO_BYTES / 4,
   parameter int AW = 9
) (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [15:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // line and comparator pins, asynchronous
   input wire logic line_se0_in,
   input wire logic line_j_in,
   input wire logic line_k_in,
   input wire logic id_pin_in,
   input wire logic vbus_avalid_in,
   input wire logic vbus_bvalid_in,
   // packet engine side
   input wire logic sof_valid_in,
   input wire logic [10:0] sof_frame_in,
   input wire logic rx_push_in,
   input wire logic [31:0] rx_data_in,
   input wire logic tx_pop_in,
   input wire logic [2:0] tx_sel_in,
   output logic [31:0] tx_data_out,
   output logic tx_valid_out,
   output logic [4:0] fifo_empty_out,
   output logic [4:0] fifo_full_out,
   output logic [2:0] push_chan_out,
   // line drive and power
   output logic dp_pullup_out,
   output logic drive_k_out,
   output logic srp_pulse_out,
   output logic clk_gate_out,
   output logic port_suspend_out,
   output logic host_role_out
);
   localparam int NREG = `OTGC_NREG;
   localparam int TW = `OTGC_TW;
   localparam int BUSRST_CYC = (`OTGC_BUS_RST_NS * `OTGC_CLK_MHZ + 999) / 1000;

   otgc_pkg::otgc_state_type st_reg;
   logic [5:0] sy1_reg, sy2_reg;
   logic se0_s, j_s, k_s, idp_s, av_s, bv_s, j_d_reg;
   logic a_dev, host_role, dev_mode, powered;
   logic [TW-1:0] tmr_reg, idle_cnt_reg, frame_cnt_reg;
   logic [6:0] rst_cnt_reg;
   logic rst_seen_reg, frame_run_reg;
   logic [10:0] frame_reg;
   logic [6:0] gif_reg, gif_ev;
   logic ev_rst, ev_enum, ev_eopf, ev_susp, ev_wkup, ev_sesi, ev_sof;
   logic session_request_bit_reg, negotiation_request_bit_reg, session_request_success_reg, negotiation_success_bit_reg, hnp_swap_reg;
   logic srp_pend_reg, hnp_se0_reg, hnp_win, hnp_tmo, srp_end;
   logic rwk_reg, sd_reg, vbig_reg, psp_reg;
   logic [7:0] chtype_reg;
   logic [31:0] len_reg [NREG];
   logic [31:0] mem_reg [WORDS];
   logic [31:0] rd_next, rx_word;
   logic wr_go, rd_go, win, win_ok, bus_push, rx_pop;
   logic [3:0] wsel;
   logic [2:0] widx, breg;
   logic [NREG-1:0] push_w, pop_w, full_w, empty_w;
   logic [AW-1:0] ra_w [NREG];
   logic [AW-1:0] wa_w [NREG];

   // pin synchronisers, second stage only is read
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sy1_reg <= '0;
         sy2_reg <= '0;
      end else if (ce_in) begin
         sy1_reg <= {line_se0_in, line_j_in, line_k_in, id_pin_in, vbus_avalid_in,
                     vbus_bvalid_in};
         sy2_reg <= sy1_reg;
      end
   end
   assign {se0_s, j_s, k_s, idp_s, av_s, bv_s} = sy2_reg;

   assign a_dev = !idp_s;
   assign host_role = a_dev ^ hnp_swap_reg;
   assign dev_mode = !host_role;
   assign powered = bv_s || vbig_reg;

   // register port decode
   assign wr_go = ce_in && reg_wr_in;
   assign rd_go = ce_in && reg_rd_in;
   assign win = reg_addr_in[15:12] != 4'h0;
   assign wsel = reg_addr_in[15:12] - 4'h1;
   assign widx = wsel[2:0];
   assign win_ok = win && (host_role ? (wsel < 4'h8) : (wsel < 4'h4));
   // host windows pick the shared region by channel type
   assign breg = host_role ? (chtype_reg[widx] ? 3'h2 : 3'h1) : widx + 3'h1;
   assign bus_push = wr_go && win_ok;
   assign rx_pop = rd_go && (win_ok || reg_addr_in == `OTGC_A_RSTAT_POP);

   // bus reset and enumeration events
   assign ev_rst = dev_mode && se0_s && rst_cnt_reg == 7'(BUSRST_CYC - 1);
   assign ev_enum = rst_seen_reg && !se0_s;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rst_cnt_reg <= '0;
         rst_seen_reg <= 1'b0;
      end else if (ce_in) begin
         if (!se0_s || !dev_mode)
            rst_cnt_reg <= '0;
         else if (rst_cnt_reg != 7'(BUSRST_CYC))
            rst_cnt_reg <= rst_cnt_reg + 7'h01;
         if (ev_rst)
            rst_seen_reg <= 1'b1;
         else if (ev_enum)
            rst_seen_reg <= 1'b0;
      end
   end

   // sof and frame timer
   assign ev_sof = dev_mode && sof_valid_in;
   assign ev_eopf = frame_run_reg && frame_cnt_reg == TW'(EOPF_CYC - 1);
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         frame_reg <= '0;
         frame_cnt_reg <= '0;
         frame_run_reg <= 1'b0;
      end else if (ce_in) begin
         if (ev_sof) begin
            frame_reg <= sof_frame_in;
            frame_cnt_reg <= '0;
            frame_run_reg <= 1'b1;
         end else if (frame_run_reg) begin
            frame_cnt_reg <= frame_cnt_reg + TW'(1);
            if (ev_eopf)
               frame_run_reg <= 1'b0;
         end
      end
   end

   // device link state
   assign ev_susp = st_reg == otgc_pkg::ST_ATT && dev_mode && powered && j_s &&
                    idle_cnt_reg == TW'(SUSP_CYC - 1);
   assign ev_wkup = st_reg == otgc_pkg::ST_SUSP && dev_mode && powered && k_s;
   assign srp_end = st_reg == otgc_pkg::ST_SRP && tmr_reg == TW'(SRP_CYC - 1);
   assign hnp_win = st_reg == otgc_pkg::ST_HNP && hnp_se0_reg && j_s;
   assign hnp_tmo = st_reg == otgc_pkg::ST_HNP && !hnp_win &&
                    tmr_reg == TW'(HNP_CYC - 1);
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         idle_cnt_reg <= '0;
      end else if (ce_in) begin
         if (st_reg == otgc_pkg::ST_ATT && j_s && !ev_susp)
            idle_cnt_reg <= idle_cnt_reg + TW'(1);
         else
            idle_cnt_reg <= '0;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         st_reg <= otgc_pkg::ST_OFF;
         tmr_reg <= '0;
         hnp_se0_reg <= 1'b0;
      end else if (ce_in) begin
         tmr_reg <= tmr_reg + TW'(1);
         case (st_reg)
            otgc_pkg::ST_OFF: begin
               if (dev_mode && powered) begin
                  st_reg <= otgc_pkg::ST_ATT;
               end else if (dev_mode && !a_dev && session_request_bit_reg) begin
                  st_reg <= otgc_pkg::ST_SRP;
                  tmr_reg <= '0;
               end
            end
            otgc_pkg::ST_ATT: begin
               if (!dev_mode || !powered)
                  st_reg <= otgc_pkg::ST_OFF;
               else if (ev_susp)
                  st_reg <= otgc_pkg::ST_SUSP;
            end
            otgc_pkg::ST_SUSP: begin
               hnp_se0_reg <= 1'b0;
               tmr_reg <= '0;
               if (!dev_mode || !powered)
                  st_reg <= otgc_pkg::ST_OFF;
               else if (k_s || se0_s)
                  st_reg <= otgc_pkg::ST_ATT;
               else if (rwk_reg)
                  st_reg <= otgc_pkg::ST_RWAKE;
               else if (negotiation_request_bit_reg && !a_dev)
                  st_reg <= otgc_pkg::ST_HNP;
            end
            otgc_pkg::ST_RWAKE: begin
               if (tmr_reg == TW'(RWAKE_CYC - 1))
                  st_reg <= otgc_pkg::ST_ATT;
            end
            otgc_pkg::ST_SRP: begin
               if (srp_end)
                  st_reg <= otgc_pkg::ST_OFF;
            end
            otgc_pkg::ST_HNP: begin
               if (se0_s)
                  hnp_se0_reg <= 1'b1;
               if (hnp_win)
                  st_reg <= otgc_pkg::ST_OFF;
               else if (hnp_tmo)
                  st_reg <= otgc_pkg::ST_SUSP;
            end
            default: st_reg <= otgc_pkg::ST_OFF;
         endcase
      end
   end

   // line drive; pull-up only in attached states of a powered device
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         dp_pullup_out <= 1'b0;
         drive_k_out <= 1'b0;
         srp_pulse_out <= 1'b0;
         clk_gate_out <= 1'b0;
      end else if (ce_in) begin
         dp_pullup_out <= dev_mode && powered && !sd_reg &&
                          (st_reg == otgc_pkg::ST_ATT || st_reg == otgc_pkg::ST_SUSP ||
                           st_reg == otgc_pkg::ST_RWAKE);
         drive_k_out <= st_reg == otgc_pkg::ST_RWAKE;
         srp_pulse_out <= st_reg == otgc_pkg::ST_SRP;
         clk_gate_out <= st_reg == otgc_pkg::ST_SUSP;
      end
   end
   assign host_role_out = host_role;
   assign port_suspend_out = psp_reg;

   // sticky flags, write one to clear; a new event beats the clear
   assign ev_sesi = a_dev && !av_s && j_s && !j_d_reg;
   assign gif_ev = {ev_sesi, ev_susp, ev_wkup, ev_eopf, ev_sof, ev_enum, ev_rst};
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         gif_reg <= '0;
         j_d_reg <= 1'b0;
      end else if (ce_in) begin
         j_d_reg <= j_s;
         if (wr_go && reg_addr_in == `OTGC_A_GIF)
            gif_reg <= (gif_reg & ~reg_wdata_in[6:0]) | gif_ev;
         else
            gif_reg <= gif_reg | gif_ev;
      end
   end

   // otg control and status
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         session_request_bit_reg <= 1'b0;
         negotiation_request_bit_reg <= 1'b0;
         session_request_success_reg <= 1'b0;
         negotiation_success_bit_reg <= 1'b0;
         hnp_swap_reg <= 1'b0;
         srp_pend_reg <= 1'b0;
      end else if (ce_in) begin
         if (wr_go && reg_addr_in == `OTGC_A_CS) begin
            session_request_bit_reg <= reg_wdata_in[`OTGC_CS_SESSION_REQUEST_BIT];
            negotiation_request_bit_reg <= reg_wdata_in[`OTGC_CS_NEGOTIATION_REQUEST_BIT];
            if (reg_wdata_in[`OTGC_CS_SESSION_REQUEST_BIT])
               session_request_success_reg <= 1'b0;
            if (reg_wdata_in[`OTGC_CS_NEGOTIATION_REQUEST_BIT])
               negotiation_success_bit_reg <= 1'b0;
         end
         if (srp_end) begin
            session_request_bit_reg <= 1'b0;
            srp_pend_reg <= 1'b1;
         end
         if (srp_pend_reg && bv_s) begin
            session_request_success_reg <= 1'b1;
            srp_pend_reg <= 1'b0;
         end
         if (!av_s && !bv_s)
            hnp_swap_reg <= 1'b0;
         if (hnp_tmo)
            negotiation_request_bit_reg <= 1'b0;
         if (hnp_win) begin
            negotiation_success_bit_reg <= 1'b1;
            negotiation_request_bit_reg <= 1'b0;
            hnp_swap_reg <= 1'b1;
         end
      end
   end

   // device, host and config bits
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rwk_reg <= 1'b0;
         sd_reg <= 1'b0;
         vbig_reg <= 1'b0;
         psp_reg <= 1'b0;
         chtype_reg <= '0;
      end else if (wr_go) begin
         case (reg_addr_in)
            `OTGC_A_DCTL: {sd_reg, rwk_reg} <= reg_wdata_in[1:0];
            `OTGC_A_GCFG: vbig_reg <= reg_wdata_in[0];
            `OTGC_A_HPCS: psp_reg <= reg_wdata_in[0];
            `OTGC_A_CHTYPE: chtype_reg <= reg_wdata_in[7:0];
            default: ;
         endcase
      end
   end

   // packet fifo regions: 0 receive, 1..4 transmit
   genvar g;
   for (g = 0; g < NREG; g++) begin : g_region
      logic [AW-1:0] rp_reg, wp_reg, dep;
      logic [AW:0] cnt_reg;
      logic push_ok, pop_ok;
      assign dep = len_reg[g][`OTGC_F_DEPTH];
      assign empty_w[g] = cnt_reg == '0;
      assign full_w[g] = cnt_reg >= {1'b0, dep};
      assign push_ok = push_w[g] && !full_w[g];
      assign pop_ok = pop_w[g] && !empty_w[g];
      assign ra_w[g] = len_reg[g][`OTGC_F_START] + rp_reg;
      assign wa_w[g] = len_reg[g][`OTGC_F_START] + wp_reg;
      if (g == 0) begin : g_rx
         assign push_w[g] = rx_push_in;
         assign pop_w[g] = rx_pop;
      end else begin : g_tx
         assign push_w[g] = bus_push && breg == 3'(g);
         assign pop_w[g] = tx_pop_in && tx_sel_in == 3'(g);
      end
      always_ff @(posedge clk_sys_in) begin
         if (!rst_n_in) begin
            len_reg[g] <= {7'h0, (g == 0) ? `OTGC_RX_DEPTH_RST : `OTGC_TX_DEPTH_RST,
                           7'h0, (g == 0) ? 9'h000 : AW'(`OTGC_RX_DEPTH_RST +
                           `OTGC_TX_DEPTH_RST * (g - 1))};
            rp_reg <= '0;
            wp_reg <= '0;
            cnt_reg <= '0;
         end else if (ce_in) begin
            if (wr_go && reg_addr_in == `OTGC_A_RXLEN + 16'(4 * g)) begin
               // resizing drops the region's contents
               len_reg[g] <= reg_wdata_in & 32'h01ff01ff;
               rp_reg <= '0;
               wp_reg <= '0;
               cnt_reg <= '0;
            end else begin
               if (push_ok)
                  wp_reg <= (wp_reg == dep - AW'(1)) ? '0 : wp_reg + AW'(1);
               if (pop_ok)
                  rp_reg <= (rp_reg == dep - AW'(1)) ? '0 : rp_reg + AW'(1);
               cnt_reg <= cnt_reg + (AW + 1)'(push_ok) - (AW + 1)'(pop_ok);
            end
         end
      end
   end
   assign fifo_empty_out = empty_w;
   assign fifo_full_out = full_w;

   // storage: link pushes receive data, bus pushes transmit data
   always_ff @(posedge clk_sys_in) begin
      if (ce_in) begin
         if (push_w[0] && !full_w[0] && int'(wa_w[0]) < WORDS)
            mem_reg[wa_w[0]] <= rx_data_in;
         if (bus_push && !full_w[breg] && int'(wa_w[breg]) < WORDS)
            mem_reg[wa_w[breg]] <= reg_wdata_in;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tx_data_out <= '0;
         tx_valid_out <= 1'b0;
         push_chan_out <= '0;
      end else if (ce_in) begin
         tx_valid_out <= 1'b0;
         if (tx_pop_in && int'(tx_sel_in) < NREG && tx_sel_in != 3'h0 &&
             !empty_w[tx_sel_in] && int'(ra_w[tx_sel_in]) < WORDS) begin
            tx_data_out <= mem_reg[ra_w[tx_sel_in]];
            tx_valid_out <= 1'b1;
         end
         if (bus_push)
            push_chan_out <= widx;
      end
   end

   // read path, data one cycle after the strobe
   assign rx_word = (!empty_w[0] && int'(ra_w[0]) < WORDS) ? mem_reg[ra_w[0]] : '0;
   always_comb begin
      rd_next = '0;
      case (reg_addr_in)
         `OTGC_A_CS: rd_next = {25'h0, negotiation_success_bit_reg, negotiation_request_bit_reg, session_request_success_reg, session_request_bit_reg,
                                bv_s, av_s, idp_s};
         `OTGC_A_GIF: rd_next = {24'h0, host_role, gif_reg};
         `OTGC_A_DCTL: rd_next = {30'h0, sd_reg, rwk_reg};
         `OTGC_A_DSTAT: rd_next = {13'h0, frame_reg, 5'h0, `OTGC_SPEED_FULL,
                                   st_reg == otgc_pkg::ST_SUSP};
         `OTGC_A_GCFG: rd_next = {31'h0, vbig_reg};
         `OTGC_A_RXLEN: rd_next = len_reg[0];
         `OTGC_A_TXLEN0: rd_next = len_reg[1];
         `OTGC_A_TXLEN1: rd_next = len_reg[2];
         `OTGC_A_TXLEN2: rd_next = len_reg[3];
         `OTGC_A_TXLEN3: rd_next = len_reg[4];
         `OTGC_A_HPCS: rd_next = {31'h0, psp_reg};
         `OTGC_A_RSTAT_RD, `OTGC_A_RSTAT_POP: rd_next = rx_word;
         `OTGC_A_CHTYPE: rd_next = {24'h0, chtype_reg};
         default: rd_next = win_ok ? rx_word : '0;
      endcase
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in)
         reg_rdata_out <= '0;
      else if (ce_in)
         reg_rdata_out <= rd_go ? rd_next : '0;
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_susp_entry;
      ce_in && ev_susp;
   endsequence
   sequence s_resume;
      ce_in && ev_wkup;
   endsequence
   AST_BUS_RST: assert property (ce_in && ev_rst |=> gif_reg[`OTGC_GIF_RST])
      else $error("bus reset flag not set");
   AST_ES_FULL: assert property (rd_go && reg_addr_in == `OTGC_A_DSTAT |=>
      reg_rdata_out[2:1] == `OTGC_SPEED_FULL) else $error("speed field not full");
   AST_ENUM: assert property (ce_in && ev_enum |=> gif_reg[`OTGC_GIF_ENUM] &&
      !rst_seen_reg) else $error("enumeration done missing");
   AST_SUSPEND: assert property (s_susp_entry |=> st_reg == otgc_pkg::ST_SUSP &&
      gif_reg[`OTGC_GIF_SUSP]) else $error("suspend not entered");
   AST_WAKEUP: assert property (s_resume |=> gif_reg[`OTGC_GIF_WKUP] &&
      st_reg == otgc_pkg::ST_ATT) else $error("wakeup not flagged");
   AST_RWAKE: assert property (ce_in && st_reg == otgc_pkg::ST_RWAKE |=>
      drive_k_out) else $error("remote wakeup not driven");
   AST_SOFT_DISC: assert property (ce_in && sd_reg |=> !dp_pullup_out)
      else $error("pull-up on during soft disconnect");
   AST_UNPOWERED: assert property (ce_in && !bv_s && !vbig_reg |=> !dp_pullup_out)
      else $error("pull-up on without power");
   AST_SOF: assert property (ce_in && ev_sof |=> gif_reg[`OTGC_GIF_SOF] &&
      frame_reg == $past(sof_frame_in) && frame_cnt_reg == '0)
      else $error("sof not tracked");
   AST_EOPF: assert property (ce_in && ev_eopf |=> gif_reg[`OTGC_GIF_EOPF] &&
      !frame_run_reg) else $error("end of frame flag missing");
   AST_ID: assert property (rd_go && reg_addr_in == `OTGC_A_CS |=>
      reg_rdata_out[0] == $past(idp_s)) else $error("id status wrong");
   AST_SESI: assert property (ce_in && ev_sesi |=> gif_reg[`OTGC_GIF_SESI])
      else $error("session request not flagged");
endmodule
`default_nettype wire

// ---- test/otgc_host_model.sv ----
// host side bus model: line state, vbus supply and sof beats
`timescale 1ns/1ns
`default_nettype none
module otgc_host_model (
   // clock
   input wire logic clk_sys_in,
   // device drive
   input wire logic dp_pullup_in,
   // line, power, packet beats
   output logic line_se0_out,
   output logic line_j_out,
   output logic line_k_out,
   output logic vbus_bvalid_out,
   output logic sof_valid_out,
   output logic [10:0] sof_frame_out
);
   logic [1:0] st_reg = 2'h1;
   // without the pull-up the host pull-downs hold se0
   assign line_se0_out = !dp_pullup_in || st_reg == 2'h0;
   assign line_j_out = dp_pullup_in && st_reg == 2'h1;
   assign line_k_out = dp_pullup_in && st_reg == 2'h2;
   initial begin
      vbus_bvalid_out = 1'b0;
      sof_valid_out = 1'b0;
      sof_frame_out = 11'h000;
   end
   task automatic power(input logic on);
      @(posedge clk_sys_in);
      vbus_bvalid_out <= on;
   endtask
   // idle is j between frames, so silence is what lets the device suspend
   task automatic drive(input logic [1:0] s, input int n);
      @(posedge clk_sys_in);
      st_reg <= s;
      repeat (n) @(posedge clk_sys_in);
      st_reg <= 2'h1;
   endtask
   task automatic sof(input logic [10:0] f);
      @(posedge clk_sys_in);
      sof_valid_out <= 1'b1;
      sof_frame_out <= f;
      @(posedge clk_sys_in);
      sof_valid_out <= 1'b0;
      sof_frame_out <= ~f;
   endtask
endmodule
`default_nettype wire

// ---- test/otgc_core_bench.sv ----
// self-checking bench of the otg controller core
`timescale 1ns/1ns
`default_nettype none
module otgc_core_bench;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [15:0] a = 16'h0000;
   logic [31:0] wd = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic id = 1'b1;
   logic av = 1'b0;
   logic rxp = 1'b0;
   logic txp = 1'b0;
   logic ce = 1'b1;
   logic [2:0] ts = 3'h4;
   logic hr, ps;
   logic [31:0] rdat, txd, d;
   logic txv, dk, cg, pu, se0, lj, lk, bv, sv;
   logic [10:0] sf;
   logic [2:0] obs;
   int miscompares = 0;
   int n_tests = 0;
   assign obs = {dk, cg, pu};
   always #20 clk_sys_in = !clk_sys_in;
   otgc_host_model otgc_host_model_i (.clk_sys_in(clk_sys_in), .dp_pullup_in(pu),
      .line_se0_out(se0), .line_j_out(lj), .line_k_out(lk), .vbus_bvalid_out(bv),
      .sof_valid_out(sv), .sof_frame_out(sf));
   otgc_core #(.SUSP_CYC(50), .EOPF_CYC(40), .RWAKE_CYC(20), .SRP_CYC(20), .HNP_CYC(30))
   otgc_core_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .line_se0_in(se0), .line_j_in(lj), .line_k_in(lk),
      .id_pin_in(id), .vbus_avalid_in(av), .vbus_bvalid_in(bv), .sof_valid_in(sv),
      .sof_frame_in(sf), .rx_push_in(rxp), .rx_data_in(32'h5a5a5a5a), .tx_pop_in(txp),
      .tx_sel_in(ts), .tx_data_out(txd), .tx_valid_out(txv), .fifo_empty_out(),
      .fifo_full_out(), .push_chan_out(), .dp_pullup_out(pu), .drive_k_out(dk),
      .srp_pulse_out(), .clk_gate_out(cg), .port_suspend_out(ps), .host_role_out(hr));
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [15:0] ad, input logic [31:0] v);
      @(posedge clk_sys_in);
      a <= ad;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] ad);
      @(posedge clk_sys_in);
      a <= ad;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic waitv(input int i, input logic v, input int n);
      repeat (n) begin
         if (obs[i] === v) break;
         @(posedge clk_sys_in);
         #1;
      end
      chk("level", {31'h0, v}, {31'h0, obs[i]});
      if (obs[i] !== v) tally_and_finish();
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      #1 chk("pullup", 32'h0, {31'h0, pu});
      otgc_host_model_i.power(1'b1);
      waitv(0, 1'b1, 8);
      wr_reg(16'h0004, 32'hff);
      otgc_host_model_i.drive(2'h0, 70);
      repeat (4) @(posedge clk_sys_in);
      rd_reg(16'h0004);
      chk("rst_enum", 32'h3, d & 32'h3);
      rd_reg(16'h000c);
      chk("speed", 32'h3, {30'h0, d[2:1]});
      wr_reg(16'h0004, 32'hff);
      otgc_host_model_i.sof(11'h5a5);
      rd_reg(16'h000c);
      chk("frame", 32'h5a5, {21'h0, d[18:8]});
      rd_reg(16'h0004);
      chk("sof", 32'h4, d & 32'hc);
      repeat (45) @(posedge clk_sys_in);
      rd_reg(16'h0004);
      chk("eopf", 32'h8, d & 32'h8);
      $display("end link");
      wr_reg(16'h0004, 32'hff);
      waitv(1, 1'b1, 120);
      rd_reg(16'h000c);
      chk("susp", 32'h1, d & 32'h1);
      otgc_host_model_i.drive(2'h2, 10);
      rd_reg(16'h0004);
      chk("wkup", 32'h10, d & 32'h10);
      waitv(1, 1'b1, 120);
      wr_reg(16'h0008, 32'h1);
      waitv(2, 1'b1, 6);
      waitv(2, 1'b0, 60);
      wr_reg(16'h0008, 32'h2);
      waitv(0, 1'b0, 3);
      wr_reg(16'h0008, 32'h0);
      waitv(0, 1'b1, 6);
      $display("end suspend");
      wr_reg(16'h4000, 32'ha5a5a5a5);
      @(posedge clk_sys_in);
      txp <= 1'b1;
      @(posedge clk_sys_in);
      txp <= 1'b0;
      #1 chk("txv", 32'h1, {31'h0, txv});
      chk("txd", 32'ha5a5a5a5, txd);
      @(posedge clk_sys_in);
      rxp <= 1'b1;
      @(posedge clk_sys_in);
      rxp <= 1'b0;
      rd_reg(16'h1000);
      chk("rx", 32'h5a5a5a5a, d);
      $display("end fifo");
      av <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      rd_reg(16'h0000);
      chk("cs", 32'h7, d & 32'h7);
      rd_reg(16'h0004);
      chk("role", 32'h0, d & 32'h80);
      chk("role_pin", 32'h0, {31'h0, hr});
      wr_reg(16'h0028, 32'h1);
      #1 chk("psusp", 32'h1, {31'h0, ps});
      id <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      rd_reg(16'h0000);
      chk("id", 32'h0, d & 32'h1);
      rd_reg(16'h0004);
      chk("role", 32'h80, d & 32'h80);
      chk("role_pin", 32'h1, {31'h0, hr});
      $display("end otg");
      tally_and_finish();
   end
endmodule
`default_nettype wire
